// ===== design/motion_err_regs.vh
// Contract
// - linear move overrange reports 0029, decel stop
// - arc distance overflow reports 002A, decel stop
// - resume after halt disturbance reports 002B, stop
// - arc resumes only after clean decel halt
// - arc supplemental feed over max reports 002C
// - traverse feed over max reports 002C too
// - dual speed ref2 >= ref1 reports 002D
// - interrupt feed without input reports 002E
// - interrupt feed direction reversal reports 002F
`ifndef MOTION_ERR_REGS_VH
`define MOTION_ERR_REGS_VH
`define ERR_LIN_DIST 16'h0029
`define ERR_ARC_DIST 16'h002A
`define ERR_ARC_CONT 16'h002B
`define ERR_SUP_SPEED 16'h002C
`define ERR_SECOND_SPEED 16'h002D
`define ERR_NO_INPUT 16'h002E
`define ERR_POS_REVERSE 16'h002F
`define ERR_NONE 16'h0000
`define POS_W 32
`define RATE_W 32
`endif

// ===== design/motion_cmd_error_checker.v
`timescale 1ns/1ps
`default_nettype none
`include "motion_err_regs.vh"
module motion_cmd_error_checker (
  input wire sys_clk,
  input wire rst_n,
  input wire linear_start,
  input wire linear_dist_ovf,
  input wire arc_start,
  input wire arc_center_ovf,
  input wire arc_length_ovf,
  input wire arc_chord_ovf,
  input wire [`RATE_W-1:0] arc_sup_rate,
  input wire [`RATE_W-1:0] max_interp_rate,
  input wire arc_resume,
  input wire arc_decel_halt,
  input wire arc_done,
  input wire axis_error,
  input wire other_positioning,
  input wire traverse_wind_cmd,
  input wire [`RATE_W-1:0] traverse_rate,
  input wire dual_speed_move_cmd,
  input wire [`RATE_W-1:0] speed_ref1,
  input wire [`RATE_W-1:0] speed_ref2,
  input wire interrupt_feed_cmd,
  input wire interrupt_in,
  input wire dir_no_int,
  input wire dir_with_int,
  input wire err_clear,
  output reg err_flag,
  output reg [15:0] err_code,
  output reg decel_stop,
  output reg resume_ok
);
  // ********************
  // reset release and pin sync
  // ********************
  reg [1:0] rst_sync_r;
  wire rst_int_n;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_int_n = rst_sync_r[1];

  // interrupt pin is asynchronous; count a level once stages two and three agree
  reg [2:0] int_sync_r;
  reg int_level_r;
  always @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      int_sync_r <= 3'h0;
      int_level_r <= 1'b0;
    end else begin
      int_sync_r <= {int_sync_r[1:0], interrupt_in};
      if (int_sync_r[2] == int_sync_r[1])
        int_level_r <= int_sync_r[2];
    end
  end

  // ********************
  // halted arc tracking
  // ********************
  // arc_active_r: arc in motion
  // arc_halted_r: stopped by decel, may resume
  // arc_dirty_r: axis error since start, or any disturbance at or after halt
  reg arc_active_r;
  reg arc_halted_r;
  reg arc_dirty_r;
  wire arc_disturb;
  wire resume_clean;
  assign arc_disturb = axis_error || other_positioning;

  always @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      arc_active_r <= 1'b0;
    end else begin
      if (arc_done || arc_decel_halt)
        arc_active_r <= 1'b0;
      else if (arc_start || resume_clean)
        arc_active_r <= 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      arc_halted_r <= 1'b0;
    end else begin
      if (arc_start || arc_done || arc_resume)
        arc_halted_r <= 1'b0;
      else if (arc_decel_halt)
        arc_halted_r <= 1'b1;
    end
  end

  // an axis error while moving spoils a later resume as well
  always @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      arc_dirty_r <= 1'b0;
    end else begin
      if (arc_start || arc_done || arc_resume)
        arc_dirty_r <= 1'b0;
      else if (arc_decel_halt)
        arc_dirty_r <= arc_dirty_r || arc_disturb;
      else if ((arc_active_r && axis_error) || (arc_halted_r && arc_disturb))
        arc_dirty_r <= 1'b1;
    end
  end

  // ********************
  // individual checks
  // ********************
  wire lin_fail;
  wire arc_dist_fail;
  wire resume_fail;
  wire arc_rate_fail;
  wire wind_rate_fail;
  wire dual_fail;
  wire no_input_fail;
  wire reverse_fail;

  // target beyond the position counter
  assign lin_fail = linear_start && linear_dist_ovf;

  // any of the three arc distances overflows
  assign arc_dist_fail = arc_start && (arc_center_ovf || arc_length_ovf || arc_chord_ovf);

  // resume only from a clean decel halt, nothing in the same cycle either
  assign resume_clean = arc_resume && arc_halted_r && !arc_dirty_r && !arc_disturb;
  assign resume_fail = arc_resume && !resume_clean;

  // supplemental and traverse feeds share one ceiling
  assign arc_rate_fail = arc_start && (arc_sup_rate > max_interp_rate);
  assign wind_rate_fail = traverse_wind_cmd && (traverse_rate > max_interp_rate);

  // second speed must be strictly below the first
  assign dual_fail = dual_speed_move_cmd && (speed_ref2 >= speed_ref1);

  // input level as synchronised at the command strobe
  assign no_input_fail = interrupt_feed_cmd && !int_level_r;
  assign reverse_fail = interrupt_feed_cmd && (dir_no_int != dir_with_int);

  // ********************
  // priority, lowest code wins
  // ********************
  localparam CHECKS = 7;
  wire [CHECKS-1:0] fail_vec;
  wire [16*CHECKS-1:0] code_tab;
  wire [16*CHECKS+15:0] code_chain;
  wire hit;
  wire [15:0] code_nxt;
  wire resume_ok_nxt;

  // entry 0 holds the lowest code
  assign fail_vec = {
    reverse_fail,
    no_input_fail,
    dual_fail,
    wind_rate_fail || arc_rate_fail,
    resume_fail,
    arc_dist_fail,
    lin_fail
  };

  assign code_tab = {
    `ERR_POS_REVERSE,
    `ERR_NO_INPUT,
    `ERR_SECOND_SPEED,
    `ERR_SUP_SPEED,
    `ERR_ARC_CONT,
    `ERR_ARC_DIST,
    `ERR_LIN_DIST
  };

  // top slot is the no-error fall-through
  assign code_chain[16*CHECKS +: 16] = `ERR_NONE;

  genvar gi;
  generate
    for (gi = 0; gi < CHECKS; gi = gi + 1) begin : g_prio
      assign code_chain[16*gi +: 16] = fail_vec[gi] ? code_tab[16*gi +: 16] : code_chain[16*(gi+1) +: 16];
    end
  endgenerate

  assign hit = |fail_vec;
  assign code_nxt = code_chain[15:0];
  assign resume_ok_nxt = resume_clean;

  // ********************
  // stop request and resume grant
  // ********************
  always @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n)
      decel_stop <= 1'b0;
    else
      decel_stop <= hit;
  end

  always @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n)
      resume_ok <= 1'b0;
    else
      resume_ok <= resume_ok_nxt;
  end

  // ********************
  // error hold, a new error beats a clear
  // ********************
  always @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      err_flag <= 1'b0;
      err_code <= `ERR_NONE;
    end else if (hit) begin
      err_flag <= 1'b1;
      err_code <= code_nxt;
    end else if (err_clear) begin
      err_flag <= 1'b0;
      err_code <= `ERR_NONE;
    end
  end
endmodule
`default_nettype wire

// ===== sim/err_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module err_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic linear_start,
  input wire logic linear_dist_ovf,
  input wire logic dual_speed_move_cmd,
  input wire logic [31:0] speed_ref1,
  input wire logic [31:0] speed_ref2,
  input wire logic err_clear,
  input wire logic err_flag,
  input wire logic [15:0] err_code,
  input wire logic decel_stop
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence bad_lin; linear_start && linear_dist_ovf; endsequence
  sequence bad_dual; dual_speed_move_cmd && speed_ref2 >= speed_ref1; endsequence
  chk_lin_code: assert property (bad_lin |=> err_code == 16'h0029) else $error("lin code");
  chk_lin_stop: assert property (bad_lin |=> decel_stop && err_flag) else $error("lin stop");
  chk_dual_stop: assert property (bad_dual |=> decel_stop) else $error("dual stop");
  chk_dual_flag: assert property (bad_dual |=> err_flag) else $error("dual flag");
  chk_stop_flag: assert property (decel_stop |-> err_flag) else $error("stop flag");
  chk_flag_hold: assert property (err_flag && !err_clear |=> err_flag) else $error("flag hold");
  chk_clear_zero: assert property ($fell(err_flag) |-> err_code == 16'h0000 && $past(err_clear)) else $error("clr");
  chk_flag_cause: assert property ($rose(err_flag) |-> decel_stop) else $error("cause");
endmodule
bind motion_cmd_error_checker err_chk i_err_chk (.sys_clk(sys_clk), .rst_n(rst_n), .linear_start(linear_start),
  .linear_dist_ovf(linear_dist_ovf), .dual_speed_move_cmd(dual_speed_move_cmd), .speed_ref1(speed_ref1),
  .speed_ref2(speed_ref2), .err_clear(err_clear), .err_flag(err_flag), .err_code(err_code),
  .decel_stop(decel_stop));
`default_nettype wire

// ===== sim/host_reader.sv
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  input wire logic sys_clk,
  input wire logic hreq,
  input wire logic err_flag,
  input wire logic [15:0] err_code,
  output logic err_clear,
  output logic [15:0] seen
);
  always @(posedge sys_clk) begin
    err_clear <= hreq && err_flag;
    if (hreq && err_flag) seen <= err_code;
  end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, rst_n, hreq, err_clear, err_flag, decel_stop, resume_ok;
  logic [9:0] st;
  logic [6:0] q;
  logic [15:0] err_code, seen;
  logic [31:0] rate;
  int num_errors = 0;
  int checks = 0;
  motion_cmd_error_checker i_motion_cmd_error_checker (.sys_clk(sys_clk), .rst_n(rst_n),
    .linear_start(st[0]), .linear_dist_ovf(q[0]), .arc_start(st[1]), .arc_center_ovf(q[1]),
    .arc_length_ovf(q[2]), .arc_chord_ovf(q[3]), .arc_sup_rate(rate), .max_interp_rate(32'h64),
    .arc_resume(st[2]), .arc_decel_halt(st[3]), .arc_done(st[4]), .axis_error(st[8]),
    .other_positioning(st[9]), .traverse_wind_cmd(st[5]), .traverse_rate(rate),
    .dual_speed_move_cmd(st[6]), .speed_ref1(32'h64), .speed_ref2(rate), .interrupt_feed_cmd(st[7]),
    .interrupt_in(q[4]), .dir_no_int(q[5]), .dir_with_int(q[6]), .err_clear(err_clear),
    .err_flag(err_flag), .err_code(err_code), .decel_stop(decel_stop), .resume_ok(resume_ok));
  host_reader i_host_reader (.sys_clk(sys_clk), .hreq(hreq), .err_flag(err_flag),
    .err_code(err_code), .err_clear(err_clear), .seen(seen));
  always #5 sys_clk = ~sys_clk;
  task chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task fire(input logic [9:0] m, input logic [6:0] v, input logic [15:0] c, input logic ok);
    @(posedge sys_clk);
    st <= m;
    q <= v;
    @(posedge sys_clk);
    st <= 10'h0;
    #1 chk(err_code, c);
    chk(decel_stop, c != 16'h0);
    chk(err_flag, c != 16'h0);
    chk(resume_ok, ok);
    if (c != 16'h0) begin
      @(posedge sys_clk) hreq <= 1'b1;
      @(posedge sys_clk) hreq <= 1'b0;
      @(posedge sys_clk);
      #1 chk(seen, c);
      chk(err_flag, 1'b0);
    end
  endtask
  task t_cmds;
    fire(10'h1, 7'h1, 16'h0029, 0);
    for (int i = 1; i < 4; i++) fire(10'h2, 7'h1 << i, 16'h002A, 0);
    fire(10'h2, 7'h0, 16'h002C, 0);
    fire(10'h20, 7'h0, 16'h002C, 0);
    fire(10'h40, 7'h0, 16'h002D, 0);
    rate <= 32'h64;
    fire(10'h2, 7'h0, 16'h0, 0);
    fire(10'h20, 7'h0, 16'h0, 0);
    fire(10'h40, 7'h0, 16'h002D, 0);
    rate <= 32'h63;
    fire(10'h40, 7'h0, 16'h0, 0);
    rate <= 32'h65;
    $display("cmds done");
  endtask
  task t_intfeed;
    fire(10'h80, 7'h0, 16'h002E, 0);
    fire(10'h0, 7'h10, 16'h0, 0);
    repeat (4) @(posedge sys_clk);
    fire(10'h80, 7'h30, 16'h002F, 0);
    $display("intfeed done");
  endtask
  task t_resume;
    rate <= 32'h64;
    fire(10'h8, 7'h0, 16'h0, 0);
    fire(10'h4, 7'h0, 16'h0, 1);
    for (int i = 8; i < 10; i++) begin
      fire(10'h8, 7'h0, 16'h0, 0);
      fire(10'h1 << i, 7'h0, 16'h0, 0);
      fire(10'h4, 7'h0, 16'h002B, 0);
    end
    fire(10'h2, 7'h0, 16'h0, 0);
    fire(10'h100, 7'h0, 16'h0, 0);
    fire(10'h8, 7'h0, 16'h0, 0);
    fire(10'h4, 7'h0, 16'h002B, 0);
    $display("resume done");
  endtask
  task wrap_up;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    sys_clk = 0;
    rst_n = 0;
    hreq = 0;
    st = 10'h0;
    q = 7'h0;
    rate = 32'h65;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_cmds;
    t_intfeed;
    t_resume;
    wrap_up;
  end
  initial begin
    #20000;
    num_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
